/* hw/dpl_cfg.svh */
`ifndef DPL_CFG_SVH
`define DPL_CFG_SVH

// byte addresses on the management port
`define DPL_ADDR_REF0_HI      16'h0017
`define DPL_ADDR_REF0_MID     16'h0018
`define DPL_ADDR_REF0_LO      16'h0019
`define DPL_ADDR_REF1_HI      16'h001A
`define DPL_ADDR_REF1_MID     16'h001B
`define DPL_ADDR_REF1_LO      16'h001C
`define DPL_ADDR_BW           16'h0023
`define DPL_ADDR_DAMP_GAIN    16'h0024
`define DPL_ADDR_SLOPE_HOLD   16'h002F
`define DPL_ADDR_LOCK_WIN     16'h0030
`define DPL_ADDR_MOD_INT_HI   16'h0031
`define DPL_ADDR_MOD_INT_LO   16'h0032
`define DPL_ADDR_MOD_FRAC_HI  16'h0033
`define DPL_ADDR_MOD_FRAC_MID 16'h0034
`define DPL_ADDR_MOD_FRAC_LO  16'h0035
`define DPL_ADDR_MOD_ORDER    16'h003A
`define DPL_ADDR_FIXED_A      16'h002B
`define DPL_ADDR_FIXED_B      16'h002C
`define DPL_ADDR_FIXED_C      16'h002D
`define DPL_ADDR_FIXED_D      16'h002E
`define DPL_ADDR_FIXED_E      16'h0037
`define DPL_FIXED_ONES        8'hFF
`define DPL_FIXED_ONE         8'h01

// field positions, low bit of each field
`define DPL_POS_LOCKED_BW     4
`define DPL_POS_ACQUIRE_BW    0
`define DPL_POS_LOCKED_DAMP   5
`define DPL_POS_ACQUIRE_DAMP  2
`define DPL_POS_FILTER_GAIN   0
`define DPL_POS_SLOPE         6
`define DPL_POS_HOLD_MODE     3
`define DPL_POS_HOLD_AVG      1
`define DPL_POS_FAST_LOCK     0
`define DPL_POS_MOD_ORDER     6
`define DPL_POS_OSC_GAIN      4
`define DPL_POS_DITHER        0

// reset values
`define DPL_RST_FB_RATIO      24'h070000
`define DPL_RST_BW            4'h7
`define DPL_RST_DAMP          3'h3
`define DPL_RST_FILTER_GAIN   2'h1
`define DPL_RST_SLOPE         2'h0
`define DPL_RST_HOLD_MODE     2'h0
`define DPL_RST_HOLD_AVG      1'h0
`define DPL_RST_FAST_LOCK     1'h0
`define DPL_RST_LOCK_WIN      8'h3F
`define DPL_RST_MOD_INT       9'h02D
`define DPL_RST_MOD_FRAC      21'h000000
`define DPL_RST_MOD_ORDER     2'h3
`define DPL_RST_OSC_GAIN      2'h1
`define DPL_RST_DITHER        3'h0

// code table limits and timing
`define DPL_BW_CODE_MIN       4'h3
`define DPL_BW_CODE_MAX       4'hB
`define DPL_LOCK_STEP_PS      20'h009C4
`define DPL_SLOPE_FAST_US     7'h53
`define DPL_SLOPE_SLOW_US     7'h0D

`endif

/* hw/dpl_pkg.sv */
`default_nettype none
package dpl_pkg;

  typedef enum logic {
    DPL_ACQUIRE,
    DPL_TRACK
  } dpl_phase_t;

  typedef struct packed {
    logic [23:0] ref0_feedback_ratio;
    logic [23:0] ref1_feedback_ratio;
    logic [3:0]  locked_bandwidth;
    logic [3:0]  acquire_bandwidth;
    logic [2:0]  locked_damping;
    logic [2:0]  acquire_damping;
    logic [1:0]  loop_filter_gain;
    logic [1:0]  phase_slope_limit;
    logic [1:0]  holdover_mode;
    logic        holdover_average_enable;
    logic        fast_lock_enable;
    logic [7:0]  lock_window;
    logic [8:0]  modulator_integer;
    logic [20:0] modulator_fraction;
    logic [1:0]  modulator_order;
    logic [1:0]  oscillator_error_gain;
    logic [2:0]  dither_gain;
  } dpl_regs_t;

endpackage
`default_nettype wire

/* hw/dpl_sync.sv */
`default_nettype none
module dpl_sync
  import dpl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_meta = d;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;

endmodule
`default_nettype wire

/* hw/dpl_feedback_cfg.sv */
// Behaviour
// - ref0 ratio, three bytes, msb first, 070000
// - ref1 ratio at 1A-1C, same reset
// - locked bandwidth code doubles from 1.40625 Hz
// - acquire bandwidth same table, resets 0111
// - locked damping codes 1,2,5,10,20, reset 011
// - acquire damping used while unlocked with fast lock on, reset 011
// - filter gain 0.5/1/1.5/2, reset 01
// - fast lock picks acquire values until locked
// - lock window 2.5 ns steps, never zero; zero is flagged, not corrected
// - slope code: none, 83, 13 us/s
// - modulator order off/1/2/3, reset 11
`include "dpl_cfg.svh"
`default_nettype none
module dpl_feedback_cfg
  import dpl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        phase_locked,
  output logic      [23:0] ref0_feedback_ratio,
  output logic      [23:0] ref1_feedback_ratio,
  output logic      [8:0]  modulator_integer,
  output logic      [20:0] modulator_fraction,
  output logic      [1:0]  holdover_mode,
  output logic             holdover_average_enable,
  output logic             acquiring,
  output logic      [3:0]  bw_code,
  output logic      [3:0]  bw_doublings,
  output logic             bw_reserved,
  output logic      [2:0]  damp_code,
  output logic      [4:0]  damp_factor,
  output logic             damp_reserved,
  output logic      [2:0]  filter_gain_halves,
  output logic      [6:0]  slope_us_per_s,
  output logic             slope_limited,
  output logic             slope_reserved,
  output logic             modulator_enable,
  output logic      [1:0]  modulator_order,
  output logic      [3:0]  osc_gain_halves,
  output logic      [6:0]  dither_lsbs,
  output logic      [19:0] lock_window_ps,
  output logic             lock_window_invalid
);

  dpl_regs_t  cfg_ff;
  dpl_regs_t  nxt_cfg;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  dpl_phase_t phase_ff;
  dpl_phase_t nxt_phase;
  logic       locked_sync;

  logic [3:0]  bw_code_ff;
  logic [3:0]  bw_dbl_ff;
  logic        bw_rsv_ff;
  logic [2:0]  damp_code_ff;
  logic [4:0]  damp_fac_ff;
  logic        damp_rsv_ff;
  logic [2:0]  gain_ff;
  logic [6:0]  slope_ff;
  logic        slope_lim_ff;
  logic        slope_rsv_ff;
  logic        mod_en_ff;
  logic [3:0]  osc_ff;
  logic [6:0]  dith_ff;
  logic [19:0] win_ps_ff;
  logic        win_bad_ff;
  logic [3:0]  nxt_bw_code;
  logic [3:0]  nxt_bw_dbl;
  logic        nxt_bw_rsv;
  logic [2:0]  nxt_damp_code;
  logic [4:0]  nxt_damp_fac;
  logic        nxt_damp_rsv;
  logic [2:0]  nxt_gain;
  logic [6:0]  nxt_slope;
  logic        nxt_slope_lim;
  logic        nxt_slope_rsv;
  logic        nxt_mod_en;
  logic [3:0]  nxt_osc;
  logic [6:0]  nxt_dith;
  logic [19:0] nxt_win_ps;
  logic        nxt_win_bad;

  // lock status comes from the loop's own detector, not this clock
  dpl_sync u_lock_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (phase_locked),
    .q       (locked_sync)
  );

  // register writes; reserved bits are dropped, they read as zero
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (reg_wr)
    begin
      case (reg_addr)
        `DPL_ADDR_REF0_HI:      nxt_cfg.ref0_feedback_ratio[23:16] = reg_wdata;
        `DPL_ADDR_REF0_MID:     nxt_cfg.ref0_feedback_ratio[15:8]  = reg_wdata;
        `DPL_ADDR_REF0_LO:      nxt_cfg.ref0_feedback_ratio[7:0]   = reg_wdata;
        `DPL_ADDR_REF1_HI:      nxt_cfg.ref1_feedback_ratio[23:16] = reg_wdata;
        `DPL_ADDR_REF1_MID:     nxt_cfg.ref1_feedback_ratio[15:8]  = reg_wdata;
        `DPL_ADDR_REF1_LO:      nxt_cfg.ref1_feedback_ratio[7:0]   = reg_wdata;
        `DPL_ADDR_BW:
        begin
          nxt_cfg.locked_bandwidth  = reg_wdata[`DPL_POS_LOCKED_BW +: 4];
          nxt_cfg.acquire_bandwidth = reg_wdata[`DPL_POS_ACQUIRE_BW +: 4];
        end
        `DPL_ADDR_DAMP_GAIN:
        begin
          nxt_cfg.locked_damping   = reg_wdata[`DPL_POS_LOCKED_DAMP +: 3];
          nxt_cfg.acquire_damping  = reg_wdata[`DPL_POS_ACQUIRE_DAMP +: 3];
          nxt_cfg.loop_filter_gain = reg_wdata[`DPL_POS_FILTER_GAIN +: 2];
        end
        `DPL_ADDR_SLOPE_HOLD:
        begin
          nxt_cfg.phase_slope_limit       = reg_wdata[`DPL_POS_SLOPE +: 2];
          nxt_cfg.holdover_mode           = reg_wdata[`DPL_POS_HOLD_MODE +: 2];
          nxt_cfg.holdover_average_enable = reg_wdata[`DPL_POS_HOLD_AVG];
          nxt_cfg.fast_lock_enable        = reg_wdata[`DPL_POS_FAST_LOCK];
        end
        `DPL_ADDR_LOCK_WIN:     nxt_cfg.lock_window = reg_wdata;
        `DPL_ADDR_MOD_INT_HI:   nxt_cfg.modulator_integer[8] = reg_wdata[0];
        `DPL_ADDR_MOD_INT_LO:   nxt_cfg.modulator_integer[7:0] = reg_wdata;
        `DPL_ADDR_MOD_FRAC_HI:  nxt_cfg.modulator_fraction[20:16] = reg_wdata[4:0];
        `DPL_ADDR_MOD_FRAC_MID: nxt_cfg.modulator_fraction[15:8] = reg_wdata;
        `DPL_ADDR_MOD_FRAC_LO:  nxt_cfg.modulator_fraction[7:0] = reg_wdata;
        `DPL_ADDR_MOD_ORDER:
        begin
          nxt_cfg.modulator_order       = reg_wdata[`DPL_POS_MOD_ORDER +: 2];
          nxt_cfg.oscillator_error_gain = reg_wdata[`DPL_POS_OSC_GAIN +: 2];
          nxt_cfg.dither_gain           = reg_wdata[`DPL_POS_DITHER +: 3];
        end
        default:
        begin
          nxt_cfg = cfg_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_ff.ref0_feedback_ratio     <= `DPL_RST_FB_RATIO;
      cfg_ff.ref1_feedback_ratio     <= `DPL_RST_FB_RATIO;
      cfg_ff.locked_bandwidth        <= `DPL_RST_BW;
      cfg_ff.acquire_bandwidth       <= `DPL_RST_BW;
      cfg_ff.locked_damping          <= `DPL_RST_DAMP;
      cfg_ff.acquire_damping         <= `DPL_RST_DAMP;
      cfg_ff.loop_filter_gain        <= `DPL_RST_FILTER_GAIN;
      cfg_ff.phase_slope_limit       <= `DPL_RST_SLOPE;
      cfg_ff.holdover_mode           <= `DPL_RST_HOLD_MODE;
      cfg_ff.holdover_average_enable <= `DPL_RST_HOLD_AVG;
      cfg_ff.fast_lock_enable        <= `DPL_RST_FAST_LOCK;
      cfg_ff.lock_window             <= `DPL_RST_LOCK_WIN;
      cfg_ff.modulator_integer       <= `DPL_RST_MOD_INT;
      cfg_ff.modulator_fraction      <= `DPL_RST_MOD_FRAC;
      cfg_ff.modulator_order         <= `DPL_RST_MOD_ORDER;
      cfg_ff.oscillator_error_gain   <= `DPL_RST_OSC_GAIN;
      cfg_ff.dither_gain             <= `DPL_RST_DITHER;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // read data registered; a read beside a write sees the old value
  always_comb
  begin
    nxt_rvalid = reg_rd;
    nxt_rdata  = rdata_ff;
    if (reg_rd)
    begin
      case (reg_addr)
        `DPL_ADDR_REF0_HI:      nxt_rdata = cfg_ff.ref0_feedback_ratio[23:16];
        `DPL_ADDR_REF0_MID:     nxt_rdata = cfg_ff.ref0_feedback_ratio[15:8];
        `DPL_ADDR_REF0_LO:      nxt_rdata = cfg_ff.ref0_feedback_ratio[7:0];
        `DPL_ADDR_REF1_HI:      nxt_rdata = cfg_ff.ref1_feedback_ratio[23:16];
        `DPL_ADDR_REF1_MID:     nxt_rdata = cfg_ff.ref1_feedback_ratio[15:8];
        `DPL_ADDR_REF1_LO:      nxt_rdata = cfg_ff.ref1_feedback_ratio[7:0];
        `DPL_ADDR_BW:           nxt_rdata = {cfg_ff.locked_bandwidth, cfg_ff.acquire_bandwidth};
        `DPL_ADDR_DAMP_GAIN:
          nxt_rdata = {cfg_ff.locked_damping, cfg_ff.acquire_damping, cfg_ff.loop_filter_gain};
        `DPL_ADDR_SLOPE_HOLD:
          nxt_rdata = {cfg_ff.phase_slope_limit, 1'b0, cfg_ff.holdover_mode, 1'b0,
                       cfg_ff.holdover_average_enable, cfg_ff.fast_lock_enable};
        `DPL_ADDR_LOCK_WIN:     nxt_rdata = cfg_ff.lock_window;
        `DPL_ADDR_MOD_INT_HI:   nxt_rdata = {7'h00, cfg_ff.modulator_integer[8]};
        `DPL_ADDR_MOD_INT_LO:   nxt_rdata = cfg_ff.modulator_integer[7:0];
        `DPL_ADDR_MOD_FRAC_HI:  nxt_rdata = {3'h0, cfg_ff.modulator_fraction[20:16]};
        `DPL_ADDR_MOD_FRAC_MID: nxt_rdata = cfg_ff.modulator_fraction[15:8];
        `DPL_ADDR_MOD_FRAC_LO:  nxt_rdata = cfg_ff.modulator_fraction[7:0];
        `DPL_ADDR_MOD_ORDER:
          nxt_rdata = {cfg_ff.modulator_order, cfg_ff.oscillator_error_gain, 1'b0, cfg_ff.dither_gain};
        `DPL_ADDR_FIXED_A,
        `DPL_ADDR_FIXED_B,
        `DPL_ADDR_FIXED_C,
        `DPL_ADDR_FIXED_D:      nxt_rdata = `DPL_FIXED_ONES;
        `DPL_ADDR_FIXED_E:      nxt_rdata = `DPL_FIXED_ONE;
        default:                nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // acquisition until the loop reports phase lock, back on loss
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      DPL_ACQUIRE:
      begin
        if (locked_sync)
          nxt_phase = DPL_TRACK;
      end
      DPL_TRACK:
      begin
        if (!locked_sync)
          nxt_phase = DPL_ACQUIRE;
      end
      default:
      begin
        nxt_phase = DPL_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      phase_ff <= DPL_ACQUIRE;
    else
      phase_ff <= nxt_phase;
  end

  // decode of the settings the loop actually applies
  always_comb
  begin
    if (cfg_ff.fast_lock_enable && phase_ff == DPL_ACQUIRE)
    begin
      nxt_bw_code   = cfg_ff.acquire_bandwidth;
      nxt_damp_code = cfg_ff.acquire_damping;
    end
    else
    begin
      nxt_bw_code   = cfg_ff.locked_bandwidth;
      nxt_damp_code = cfg_ff.locked_damping;
    end
    // reserved bandwidth codes report zero doublings and raise a flag
    nxt_bw_rsv = (nxt_bw_code < `DPL_BW_CODE_MIN) || (nxt_bw_code > `DPL_BW_CODE_MAX);
    nxt_bw_dbl = nxt_bw_rsv ? 4'h0 : 4'(nxt_bw_code - `DPL_BW_CODE_MIN);
    nxt_damp_rsv = 1'b0;
    case (nxt_damp_code)
      3'h1:    nxt_damp_fac = 5'h01;
      3'h2:    nxt_damp_fac = 5'h02;
      3'h3:    nxt_damp_fac = 5'h05;
      3'h4:    nxt_damp_fac = 5'h0A;
      3'h5:    nxt_damp_fac = 5'h14;
      default:
      begin
        nxt_damp_fac = 5'h00;
        nxt_damp_rsv = 1'b1;
      end
    endcase
    nxt_gain      = 3'({1'b0, cfg_ff.loop_filter_gain} + 3'h1);
    nxt_slope_lim = 1'b0;
    nxt_slope_rsv = 1'b0;
    case (cfg_ff.phase_slope_limit)
      2'h1:
      begin
        nxt_slope     = `DPL_SLOPE_FAST_US;
        nxt_slope_lim = 1'b1;
      end
      2'h2:
      begin
        nxt_slope     = `DPL_SLOPE_SLOW_US;
        nxt_slope_lim = 1'b1;
      end
      2'h3:
      begin
        nxt_slope     = 7'h00;
        nxt_slope_rsv = 1'b1;
      end
      default: nxt_slope = 7'h00;
    endcase
    nxt_mod_en = (cfg_ff.modulator_order != 2'h0);
    nxt_osc    = 4'(4'h1 << cfg_ff.oscillator_error_gain);
    nxt_dith   = (cfg_ff.dither_gain == 3'h0) ? 7'h00 : 7'(7'h01 << (cfg_ff.dither_gain - 3'h1));
    // a zero window would never see lock; flagged, not corrected
    nxt_win_ps  = 20'(cfg_ff.lock_window * `DPL_LOCK_STEP_PS);
    nxt_win_bad = (cfg_ff.lock_window == 8'h00);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bw_code_ff   <= 4'h0;
      bw_dbl_ff    <= 4'h0;
      bw_rsv_ff    <= 1'b0;
      damp_code_ff <= 3'h0;
      damp_fac_ff  <= 5'h00;
      damp_rsv_ff  <= 1'b0;
      gain_ff      <= 3'h0;
      slope_ff     <= 7'h00;
      slope_lim_ff <= 1'b0;
      slope_rsv_ff <= 1'b0;
      mod_en_ff    <= 1'b0;
      osc_ff       <= 4'h0;
      dith_ff      <= 7'h00;
      win_ps_ff    <= 20'h00000;
      win_bad_ff   <= 1'b0;
    end
    else
    begin
      bw_code_ff   <= nxt_bw_code;
      bw_dbl_ff    <= nxt_bw_dbl;
      bw_rsv_ff    <= nxt_bw_rsv;
      damp_code_ff <= nxt_damp_code;
      damp_fac_ff  <= nxt_damp_fac;
      damp_rsv_ff  <= nxt_damp_rsv;
      gain_ff      <= nxt_gain;
      slope_ff     <= nxt_slope;
      slope_lim_ff <= nxt_slope_lim;
      slope_rsv_ff <= nxt_slope_rsv;
      mod_en_ff    <= nxt_mod_en;
      osc_ff       <= nxt_osc;
      dith_ff      <= nxt_dith;
      win_ps_ff    <= nxt_win_ps;
      win_bad_ff   <= nxt_win_bad;
    end
  end

  assign reg_rdata               = rdata_ff;
  assign reg_rvalid              = rvalid_ff;
  assign ref0_feedback_ratio     = cfg_ff.ref0_feedback_ratio;
  assign ref1_feedback_ratio     = cfg_ff.ref1_feedback_ratio;
  assign modulator_integer       = cfg_ff.modulator_integer;
  assign modulator_fraction      = cfg_ff.modulator_fraction;
  assign holdover_mode           = cfg_ff.holdover_mode;
  assign holdover_average_enable = cfg_ff.holdover_average_enable;
  assign modulator_order         = cfg_ff.modulator_order;
  assign acquiring               = (phase_ff == DPL_ACQUIRE);
  assign bw_code                 = bw_code_ff;
  assign bw_doublings            = bw_dbl_ff;
  assign bw_reserved             = bw_rsv_ff;
  assign damp_code               = damp_code_ff;
  assign damp_factor             = damp_fac_ff;
  assign damp_reserved           = damp_rsv_ff;
  assign filter_gain_halves      = gain_ff;
  assign slope_us_per_s          = slope_ff;
  assign slope_limited           = slope_lim_ff;
  assign slope_reserved          = slope_rsv_ff;
  assign modulator_enable        = mod_en_ff;
  assign osc_gain_halves         = osc_ff;
  assign dither_lsbs             = dith_ff;
  assign lock_window_ps          = win_ps_ff;
  assign lock_window_invalid     = win_bad_ff;

endmodule
`default_nettype wire

/* tb/dpl_feedback_cfg_checker.sv */
`default_nettype none
module dpl_feedback_cfg_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        phase_locked,
  input wire logic [23:0] ref0_feedback_ratio,
  input wire logic [23:0] ref1_feedback_ratio,
  input wire logic        acquiring,
  input wire logic [3:0]  bw_code,
  input wire logic        bw_reserved,
  input wire logic [2:0]  damp_code,
  input wire logic [4:0]  damp_factor,
  input wire logic [2:0]  filter_gain_halves,
  input wire logic [1:0]  modulator_order,
  input wire logic        modulator_enable,
  input wire logic        lock_window_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] DAMP_TAB [8] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h0A, 5'h14, 5'h00, 5'h00};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ref0_write;
    reg_wr && reg_addr == 16'h0017 |=> ref0_feedback_ratio[23:16] == $past(reg_wdata);
  endproperty
  a_ref0_write: assert property (p_ref0_write) else $error("ref0 high byte not written");
  property p_ref1_write;
    reg_wr && reg_addr == 16'h001C |=> ref1_feedback_ratio[7:0] == $past(reg_wdata);
  endproperty
  a_ref1_write: assert property (p_ref1_write) else $error("ref1 low byte not written");
  // first edge after release still shows the reset-time decode
  property p_bw_reserved;
    !$past(rst) |-> bw_reserved == (bw_code < 4'h3 || bw_code > 4'hB);
  endproperty
  a_bw_reserved: assert property (p_bw_reserved) else $error("bandwidth reserved flag wrong");
  property p_damp_table;
    !$past(rst) |-> damp_factor == DAMP_TAB[damp_code];
  endproperty
  a_damp_table: assert property (p_damp_table) else $error("damping factor wrong");
  property p_gain;
    reg_wr && reg_addr == 16'h0024 |=> ##1 filter_gain_halves == {1'b0, $past(reg_wdata[1:0], 2)} + 3'h1;
  endproperty
  a_gain: assert property (p_gain) else $error("filter gain wrong");
  property p_locked;
    // the release edge itself still sees the synchroniser held clear
    (phase_locked && !rst) [*4] |-> !acquiring;
  endproperty
  a_locked: assert property (p_locked) else $error("still acquiring after lock");
  property p_unlocked;
    !phase_locked [*4] |-> acquiring;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("not acquiring without lock");
  property p_window_zero;
    reg_wr && reg_addr == 16'h0030 |=> ##1 lock_window_invalid == ($past(reg_wdata, 2) == 8'h00);
  endproperty
  a_window_zero: assert property (p_window_zero) else $error("zero window flag wrong");
  property p_order;
    reg_wr && reg_addr == 16'h003A |=> modulator_order == $past(reg_wdata[7:6])
      ##1 modulator_enable == (modulator_order != 2'h0);
  endproperty
  a_order: assert property (p_order) else $error("modulator order wrong");
  property p_readback;
    reg_rd && reg_addr == 16'h0017 |=> reg_rvalid && reg_rdata == $past(ref0_feedback_ratio[23:16]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");
  property p_unmapped;
    reg_rd && reg_addr == 16'h0020 |=> reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* tb/dpl_feedback_cfg_test.sv */
`default_nettype none
module dpl_feedback_cfg_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0]  DAMP_TAB [8] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h0A, 5'h14, 5'h00, 5'h00};
  localparam logic [15:0] CORNER [10] = '{16'h17A5, 16'h185A, 16'h19C3, 16'h1C81, 16'h3000,
                                          16'h2FFF, 16'h3A00, 16'h2B00, 16'h3700, 16'h2312};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic        phase_locked = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid, acquiring, bw_reserved, modulator_enable, lock_window_invalid;
  logic [23:0] ref0_feedback_ratio, ref1_feedback_ratio;
  logic [3:0]  bw_code;
  logic [2:0]  damp_code, filter_gain_halves;
  logic [4:0]  damp_factor;
  logic [6:0]  slope_us_per_s;
  logic [1:0]  modulator_order;
  logic [19:0] lock_window_ps;
  logic [8:0]  modulator_integer;
  logic [20:0] modulator_fraction;
  logic [1:0]  holdover_mode;
  logic [3:0]  bw_doublings, osc_gain_halves;
  logic [6:0]  dither_lsbs;
  logic        holdover_average_enable, damp_reserved, slope_limited, slope_reserved;
  logic [7:0]  mdl [0:63];
  int          n_fail = 0;
  int          samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  dpl_feedback_cfg i_dpl_feedback_cfg (
    .clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .phase_locked,
    .ref0_feedback_ratio, .ref1_feedback_ratio, .modulator_integer, .modulator_fraction,
    .holdover_mode, .holdover_average_enable, .acquiring, .bw_code, .bw_doublings, .bw_reserved,
    .damp_code, .damp_factor, .damp_reserved, .filter_gain_halves, .slope_us_per_s, .slope_limited,
    .slope_reserved, .modulator_enable, .modulator_order, .osc_gain_halves, .dither_lsbs,
    .lock_window_ps, .lock_window_invalid
  );

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // writable bits per byte; fixed and reserved bytes keep their model value
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h23, 8'h24, 8'h30, 8'h32, 8'h34, 8'h35: wmask = 8'hFF;
      8'h2F: wmask = 8'hDB;
      8'h31: wmask = 8'h01;
      8'h33: wmask = 8'h1F;
      8'h3A: wmask = 8'hF7;
      default: wmask = 8'h00;
    endcase
  endfunction

  task automatic mdl_reset();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h17] = 8'h07;
    mdl[8'h1A] = 8'h07;
    mdl[8'h23] = 8'h77;
    mdl[8'h24] = 8'h6D;
    for (int i = 8'h2B; i <= 8'h2E; i++) mdl[i] = 8'hFF;
    mdl[8'h30] = 8'h3F;
    mdl[8'h32] = 8'h2D;
    mdl[8'h37] = 8'h01;
    mdl[8'h3A] = 8'hD0;
  endtask

  // idle edge after each strobe keeps it a one-cycle pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= {8'h00, a};
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    mdl[a[5:0]] = (mdl[a[5:0]] & ~wmask(a)) | (d & wmask(a));
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= {8'h00, a};
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 24'h000001, {23'h000000, reg_rvalid});
    chk("rdata", {16'h0000, mdl[a[5:0]]}, {16'h0000, reg_rdata});
  endtask

  task automatic sweep();
    for (int i = 0; i < 64; i++) rd(8'(i));
  endtask

  // lock input must have settled through the synchroniser before this is called
  task automatic chk_decode();
    logic       acq;
    logic [3:0] bw;
    logic [2:0] dc;
    logic [1:0] sl;
    logic [2:0] dg;
    acq = mdl[8'h2F][0] && !phase_locked;
    dg  = mdl[8'h3A][2:0];
    bw  = acq ? mdl[8'h23][3:0] : mdl[8'h23][7:4];
    dc  = acq ? mdl[8'h24][4:2] : mdl[8'h24][7:5];
    sl  = mdl[8'h2F][7:6];
    repeat (2) @(posedge clk_sys);
    #1;
    chk("acquiring", !phase_locked, acquiring);
    chk("bw_code", bw, bw_code);
    chk("bw_reserved", bw < 4'h3 || bw > 4'hB, bw_reserved);
    chk("damp_factor", DAMP_TAB[dc], damp_factor);
    chk("bw_doublings", (bw < 4'h3 || bw > 4'hB) ? 4'h0 : bw - 4'h3, bw_doublings);
    chk("damp_code", dc, damp_code);
    chk("damp_reserved", dc == 3'h0 || dc > 3'h5, damp_reserved);
    chk("slope_limited", sl == 2'h1 || sl == 2'h2, slope_limited);
    chk("slope_reserved", sl == 2'h3, slope_reserved);
    chk("osc_gain", 4'h1 << mdl[8'h3A][5:4], osc_gain_halves);
    chk("dither", (dg == 3'h0) ? 7'h00 : 7'h01 << (dg - 3'h1), dither_lsbs);
    chk("mod_int", {mdl[8'h31][0], mdl[8'h32]}, modulator_integer);
    chk("mod_frac", {mdl[8'h33][4:0], mdl[8'h34], mdl[8'h35]}, modulator_fraction);
    chk("holdover", {mdl[8'h2F][4:3], mdl[8'h2F][1]}, {holdover_mode, holdover_average_enable});
    chk("gain", mdl[8'h24][1:0] + 3'h1, filter_gain_halves);
    chk("slope", sl == 2'h1 ? 7'h53 : sl == 2'h2 ? 7'h0D : 7'h00, slope_us_per_s);
    chk("mod_en", mdl[8'h3A][7:6] != 2'h0, modulator_enable);
    chk("window_ps", mdl[8'h30] * 20'h009C4, lock_window_ps);
    chk("window_zero", mdl[8'h30] == 8'h00, lock_window_invalid);
    chk("ref0", {mdl[8'h17], mdl[8'h18], mdl[8'h19]}, ref0_feedback_ratio);
    chk("ref1", {mdl[8'h1A], mdl[8'h1B], mdl[8'h1C]}, ref1_feedback_ratio);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial
  begin
    void'($urandom(96));
    mdl_reset();
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    sweep();
    foreach (CORNER[i]) wr(CORNER[i][15:8], CORNER[i][7:0]);
    chk_decode();
    foreach (CORNER[i]) rd(CORNER[i][15:8]);
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk_sys);
      if ($urandom_range(0, 3) == 0)
      begin
        phase_locked <= !phase_locked;
      end
      wr(8'($urandom_range(8'h10, 8'h3F)), 8'($urandom));
      rd(8'($urandom_range(0, 63)));
      chk_decode();
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    mdl_reset();
    sweep();
    chk_decode();
    finish_test();
  end
endmodule

bind dpl_feedback_cfg dpl_feedback_cfg_checker i_dpl_feedback_cfg_checker (
  .clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .phase_locked,
  .ref0_feedback_ratio, .ref1_feedback_ratio, .acquiring, .bw_code, .bw_reserved, .damp_code,
  .damp_factor, .filter_gain_halves, .modulator_order, .modulator_enable, .lock_window_invalid
);
`default_nettype wire
